// file: opsw_pkg.sv
// Package with offsets, codes, field positions and reset values of the mode switch block.
package opsw_pkg;

  // ************************************************************
  // Register map (byte addresses on the APB side).
  // ************************************************************
  localparam logic [7:0] OPSW_CMD_OFFS = 8'h00;
  localparam logic [7:0] OPSW_RESP_OFFS = 8'h04;
  localparam logic [7:0] OPSW_EVT_OFFS = 8'h08;
  localparam logic [7:0] OPSW_MODE_OFFS = 8'h0c;

  // ************************************************************
  // Instruction codes and use-case selectors.
  // ************************************************************
  localparam logic [7:0] OPSW_INSTR_NORMAL = 8'h20;
  localparam logic [7:0] OPSW_SEL_ABORT_RST = 8'h00;
  localparam logic [7:0] OPSW_SEL_POWERUP = 8'h01;
  localparam logic [7:0] OPSW_SEL_ABORT_KEEP = 8'h02;
  localparam logic [7:0] OPSW_NORMAL_LEN = 8'h00;
  // Codes of the other mode commands; the values are arbitrary.
  localparam logic [7:0] OPSW_INSTR_STANDBY = 8'h21;
  localparam logic [7:0] OPSW_INSTR_CARD_DETECT = 8'h22;
  localparam logic [7:0] OPSW_INSTR_LISTEN = 8'h23;
  localparam logic [7:0] OPSW_INSTR_EXCHANGE = 8'h10;
  localparam logic [7:0] OPSW_INSTR_TEST_SEQ = 8'h11;

  // ************************************************************
  // Status codes answered in the response register.
  // ************************************************************
  localparam logic [7:0] OPSW_INSTR_OK_STATUS = 8'h00;
  localparam logic [7:0] OPSW_INSTR_FAIL_STATUS = 8'h01;

  // ************************************************************
  // Listen mode parameter and technology mask layout.
  // ************************************************************
  localparam logic [7:0] OPSW_LISTEN_MODE_MAX = 8'h02;
  localparam logic [7:0] OPSW_LISTEN_PLAIN = 8'h00;
  localparam logic [7:0] OPSW_LISTEN_SLEEPY = 8'h01;
  localparam int OPSW_TECH_A_BIT = 0;
  localparam int OPSW_TECH_F_BIT = 1;
  localparam logic [7:0] OPSW_TECH_UNAVAIL = 8'h0c;
  localparam logic [7:0] OPSW_TECH_RSVD = 8'hf0;

  // ************************************************************
  // Event status bit positions and reset values.
  // ************************************************************
  localparam int OPSW_EVT_BOOT_BIT = 0;
  localparam int OPSW_EVT_IDLE_BIT = 1;
  localparam int OPSW_EVT_LISTEN_BIT = 2;
  localparam logic [2:0] OPSW_EVT_RESET = 3'h0;
  localparam logic [7:0] OPSW_STATUS_RESET = 8'h00;
  localparam int OPSW_SYNC_WIDTH = 4;

  // Operation states of the device.
  typedef enum logic [2:0] {
    OPSW_ST_NORMAL,
    OPSW_ST_STANDBY,
    OPSW_ST_CARD_DETECT,
    OPSW_ST_BUSY,
    OPSW_ST_LISTEN,
    OPSW_ST_LISTEN_SLEEP,
    OPSW_ST_LISTEN_WAIT
  } opsw_state_t;

endpackage

// file: opsw_sync_if.sv
// Interface carrying raw pin levels to the synchroniser and synchronised levels back.
`timescale 1ns/100ps
`default_nettype none
interface opsw_sync_if #(
  parameter int WIDTH = 4
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;

  // The synchroniser reads raw levels and drives clean ones.
  modport sync (input raw, output synced);
  // The controller feeds pins in and reads the clean levels.
  modport ctrl (output raw, input synced);
endinterface
`default_nettype wire

// file: opsw_sync.sv
// Two-flop synchroniser bank for the asynchronous pins of the mode switch block.
`timescale 1ns/100ps
`default_nettype none
module opsw_sync
  import opsw_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  opsw_sync_if.sync port
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } opsw_sync_state_t;

  opsw_sync_state_t state_reg;
  opsw_sync_state_t state_next;

  // The first stage feeds only the second stage.
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = port.raw;
    state_next.stage2 = state_reg.stage1;
  end

  // Both stages clear on reset.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.synced = state_reg.stage2;

endmodule
`default_nettype wire

// file: opsw_ctrl.sv
// Operation mode switch command interpreter with an APB register port.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module opsw_ctrl
  import opsw_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rf_field_present,
  input wire logic target_activated,
  input wire logic wake_event,
  input wire logic soft_reset_req,
  output logic frontend_reset,
  output logic rf_field_off,
  output logic transceiver_idle,
  output logic standby_active,
  output logic listen_active,
  output logic [1:0] listen_tech_enable,
  output logic irq
);

  // ************************************************************
  // Pin synchronisation.
  // ************************************************************

  opsw_sync_if #(.WIDTH(OPSW_SYNC_WIDTH)) pins ();

  // Outside pins reach the logic only through two flops.
  assign pins.raw = {soft_reset_req, wake_event, target_activated, rf_field_present};

  opsw_sync #(.WIDTH(OPSW_SYNC_WIDTH)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .port(pins)
  );

  logic field_s;
  logic target_s;
  logic wake_s;
  logic softrst_s;

  // Clean copies of the pins.
  assign field_s = pins.synced[0];
  assign target_s = pins.synced[1];
  assign wake_s = pins.synced[2];
  assign softrst_s = pins.synced[3];

  // ************************************************************
  // State of the block.
  // ************************************************************

  typedef struct packed {
    opsw_state_t mode;
    logic booted;
    logic [2:0] events;
    logic [7:0] resp_status;
    logic resp_valid;
    logic [7:0] tech_mask;
    logic [7:0] listen_mode;
    logic fe_reset;
    logic field_off;
    logic trx_idle;
    logic [31:0] rdata;
    logic err;
  } opsw_ctrl_state_t;

  opsw_ctrl_state_t state_reg;
  opsw_ctrl_state_t state_next;

  // True when the technology mask and mode allow entering listening.
  function automatic logic listen_ok(input logic [7:0] mask, input logic [7:0] lmode);
    logic ok;
    ok = 1'b1;
    if (lmode > OPSW_LISTEN_MODE_MAX) begin
      ok = 1'b0;
    end else if ((mask & (OPSW_TECH_UNAVAIL | OPSW_TECH_RSVD)) != 8'h00) begin
      ok = 1'b0;
    end else if (mask == 8'h00) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // True for any state that counts as a running listen command.
  function automatic logic in_listen(input opsw_state_t st);
    return (st == OPSW_ST_LISTEN) || (st == OPSW_ST_LISTEN_SLEEP) ||
           (st == OPSW_ST_LISTEN_WAIT);
  endfunction

  // ************************************************************
  // APB decode helpers.
  // ************************************************************

  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] c_instr;
  logic [7:0] c_sel;
  logic [7:0] c_len;
  logic [7:0] c_mode;

  // Setup and access phases, and command frame bytes from the write data.
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign c_instr = pwdata[7:0];
  assign c_sel = pwdata[15:8];
  assign c_len = pwdata[23:16];
  assign c_mode = pwdata[31:24];

  // ************************************************************
  // Next state.
  // ************************************************************

  always_comb begin
    logic cmd_wr;
    logic is_normal_cmd;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    cmd_wr = 1'b0;
    is_normal_cmd = 1'b0;
    ev_set = 3'h0;
    ev_clr = 3'h0;
    state_next = state_reg;
    state_next.fe_reset = 1'b0;
    state_next.field_off = 1'b0;
    state_next.trx_idle = 1'b0;

    // The first cycle after reset is the boot: normal mode with a boot event.
    if (!state_reg.booted) begin
      state_next.booted = 1'b1;
      state_next.mode = OPSW_ST_NORMAL;
      ev_set[OPSW_EVT_BOOT_BIT] = 1'b1;
    end

    // Register writes: command frames and event clears.
    if (wr_acc) begin
      if (paddr == OPSW_CMD_OFFS) begin
        cmd_wr = 1'b1;
      end else if (paddr == OPSW_EVT_OFFS) begin
        ev_clr = pwdata[2:0];
      end
    end

    // Frame bytes: instruction, use case, zero length.
    is_normal_cmd = cmd_wr && (c_instr == OPSW_INSTR_NORMAL) && (c_len == OPSW_NORMAL_LEN);

    // Autonomous transitions of the running modes.
    case (state_reg.mode)
      OPSW_ST_STANDBY, OPSW_ST_CARD_DETECT: begin
        if (wake_s) begin
          state_next.mode = OPSW_ST_NORMAL;
          ev_set[OPSW_EVT_IDLE_BIT] = 1'b1;
        end
      end
      OPSW_ST_LISTEN: begin
        if (target_s) begin
          state_next.mode = OPSW_ST_NORMAL;
          ev_set[OPSW_EVT_LISTEN_BIT] = 1'b1;
        end else if (!field_s) begin
          if (state_reg.listen_mode == OPSW_LISTEN_PLAIN) begin
            state_next.mode = OPSW_ST_NORMAL;
            ev_set[OPSW_EVT_LISTEN_BIT] = 1'b1;
          end else if (state_reg.listen_mode == OPSW_LISTEN_SLEEPY) begin
            state_next.mode = OPSW_ST_LISTEN_SLEEP;
          end else begin
            state_next.mode = OPSW_ST_LISTEN_WAIT;
          end
        end
      end
      OPSW_ST_LISTEN_SLEEP, OPSW_ST_LISTEN_WAIT: begin
        if (field_s) begin
          state_next.mode = OPSW_ST_LISTEN;
        end
      end
      default: begin
      end
    endcase

    // A soft reset returns to normal by itself.
    if (softrst_s && state_reg.booted) begin
      state_next.mode = OPSW_ST_NORMAL;
      ev_set[OPSW_EVT_IDLE_BIT] = 1'b1;
    end

    // Command execution; the return-to-normal frame works in every mode.
    if (is_normal_cmd && c_sel == OPSW_SEL_POWERUP) begin
      state_next.mode = OPSW_ST_NORMAL;
      ev_set[OPSW_EVT_BOOT_BIT] = 1'b1;
    end else if (is_normal_cmd && c_sel == OPSW_SEL_ABORT_RST) begin
      state_next.mode = OPSW_ST_NORMAL;
      state_next.fe_reset = 1'b1;
      state_next.field_off = 1'b1;
      state_next.trx_idle = 1'b1;
      ev_set[OPSW_EVT_IDLE_BIT] = 1'b1;
    end else if (is_normal_cmd && c_sel == OPSW_SEL_ABORT_KEEP) begin
      state_next.mode = OPSW_ST_NORMAL;
      state_next.trx_idle = 1'b1;
      ev_set[OPSW_EVT_IDLE_BIT] = 1'b1;
    end else if (cmd_wr && !is_normal_cmd) begin
      state_next.resp_valid = 1'b1;
      state_next.resp_status = OPSW_INSTR_FAIL_STATUS;
      if (state_reg.mode == OPSW_ST_NORMAL) begin
        // Normal mode takes every instruction except a listen with an illegal mode or mask.
        if (c_instr == OPSW_INSTR_LISTEN) begin
          if (listen_ok(c_sel, c_mode)) begin
            state_next.tech_mask = c_sel;
            state_next.listen_mode = c_mode;
            state_next.resp_status = OPSW_INSTR_OK_STATUS;
            if (field_s) begin
              state_next.mode = OPSW_ST_LISTEN;
            end else if (c_mode == OPSW_LISTEN_PLAIN) begin
              // No field at start ends a plain listen at once.
              ev_set[OPSW_EVT_LISTEN_BIT] = 1'b1;
            end else if (c_mode == OPSW_LISTEN_SLEEPY) begin
              state_next.mode = OPSW_ST_LISTEN_SLEEP;
            end else begin
              state_next.mode = OPSW_ST_LISTEN_WAIT;
            end
          end
        end else if (c_instr == OPSW_INSTR_STANDBY) begin
          state_next.mode = OPSW_ST_STANDBY;
          state_next.resp_status = OPSW_INSTR_OK_STATUS;
        end else if (c_instr == OPSW_INSTR_CARD_DETECT) begin
          state_next.mode = OPSW_ST_CARD_DETECT;
          state_next.resp_status = OPSW_INSTR_OK_STATUS;
        end else if (c_instr == OPSW_INSTR_EXCHANGE || c_instr == OPSW_INSTR_TEST_SEQ) begin
          state_next.mode = OPSW_ST_BUSY;
          state_next.resp_status = OPSW_INSTR_OK_STATUS;
        end else begin
          // Any other instruction is accepted and completes at once.
          state_next.resp_status = OPSW_INSTR_OK_STATUS;
        end
      end
    end

    // Reading the response register consumes it, unless a new one lands.
    if (rd_acc && paddr == OPSW_RESP_OFFS && !(cmd_wr && !is_normal_cmd)) begin
      state_next.resp_valid = 1'b0;
    end

    // Event flags: a set in the same cycle beats a clear.
    state_next.events = (state_reg.events & ~ev_clr) | ev_set;

    // Read data is captured in the setup phase and held through access.
    if (setup_ph) begin
      state_next.err = 1'b0;
      state_next.rdata = 32'h0000_0000;
      if (paddr == OPSW_CMD_OFFS) begin
        state_next.rdata = 32'h0000_0000;
      end else if (paddr == OPSW_RESP_OFFS) begin
        state_next.rdata = {23'h0, state_reg.resp_valid, state_reg.resp_status};
      end else if (paddr == OPSW_EVT_OFFS) begin
        state_next.rdata = {29'h0, state_reg.events};
      end else if (paddr == OPSW_MODE_OFFS) begin
        state_next.rdata = {8'h00, state_reg.listen_mode, state_reg.tech_mask,
                            5'h00, state_reg.mode};
      end else begin
        state_next.err = 1'b1;
      end
    end
  end

  // ************************************************************
  // State register.
  // ************************************************************

  // Everything returns to normal mode with cleared flags on reset.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg.mode <= OPSW_ST_NORMAL;
      state_reg.booted <= 1'b0;
      state_reg.events <= OPSW_EVT_RESET;
      state_reg.resp_status <= OPSW_STATUS_RESET;
      state_reg.resp_valid <= 1'b0;
      state_reg.tech_mask <= 8'h00;
      state_reg.listen_mode <= 8'h00;
      state_reg.fe_reset <= 1'b0;
      state_reg.field_off <= 1'b0;
      state_reg.trx_idle <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.err <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.err && psel && penable;

  // Frontend control pulses and mode levels.
  assign frontend_reset = state_reg.fe_reset;
  assign rf_field_off = state_reg.field_off;
  assign transceiver_idle = state_reg.trx_idle;
  assign standby_active = (state_reg.mode == OPSW_ST_STANDBY) ||
                          (state_reg.mode == OPSW_ST_LISTEN_SLEEP);
  assign listen_active = in_listen(state_reg.mode);

  // Technologies enabled only while actively listening.
  assign listen_tech_enable = (state_reg.mode == OPSW_ST_LISTEN) ?
    {state_reg.tech_mask[OPSW_TECH_F_BIT], state_reg.tech_mask[OPSW_TECH_A_BIT]} : 2'b00;

  // Pending events raise the host notification line.
  assign irq = |state_reg.events;

endmodule
`default_nettype wire

// file: opsw_ctrl_checker.sv
// Assertion checker for the ports of the mode switch command interpreter.
`timescale 1ns/100ps
`default_nettype none
module opsw_ctrl_checker
  import opsw_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rf_field_present,
  input wire logic target_activated,
  input wire logic wake_event,
  input wire logic soft_reset_req,
  input wire logic frontend_reset,
  input wire logic rf_field_off,
  input wire logic transceiver_idle,
  input wire logic standby_active,
  input wire logic listen_active,
  input wire logic [1:0] listen_tech_enable,
  input wire logic irq
);
  logic cmd_wr;
  logic abort_rst;
  logic abort_keep;
  logic [1:0] boot_cnt_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // A command write takes effect at the access edge; aborts are decoded from its low bytes.
  assign cmd_wr = psel && penable && pwrite && (paddr == OPSW_CMD_OFFS);
  assign abort_rst = cmd_wr &&
    (pwdata[23:0] == {OPSW_NORMAL_LEN, OPSW_SEL_ABORT_RST, OPSW_INSTR_NORMAL});
  assign abort_keep = cmd_wr &&
    (pwdata[23:0] == {OPSW_NORMAL_LEN, OPSW_SEL_ABORT_KEEP, OPSW_INSTR_NORMAL});

  // Counts the edges since reset release, so the boot event can be timed.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      boot_cnt_reg <= 2'h0;
    end else if (boot_cnt_reg != 2'h3) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
    end
  end

  chk_abort_rst_pulse: assert property (
    abort_rst |=> frontend_reset && rf_field_off && transceiver_idle)
    else $error("resetting abort gave no frontend restore");
  chk_abort_keep_regs: assert property (
    abort_keep |=> transceiver_idle && !frontend_reset && !rf_field_off)
    else $error("keeping abort touched the frontend");
  chk_pulse_single: assert property (frontend_reset |=> !frontend_reset)
    else $error("frontend restore longer than one cycle");
  chk_abort_to_idle: assert property (
    abort_rst || abort_keep |=> !standby_active && !listen_active)
    else $error("abort left a running mode");
  chk_tech_mask_legal: assert property (
    listen_tech_enable != 2'b00 |-> listen_active && !standby_active)
    else $error("technology enable outside active listening");
  chk_listen_end_irq: assert property ($fell(listen_active) |-> ##[0:1] irq)
    else $error("listen end without interrupt");
  chk_field_resume: assert property (
    (listen_active && standby_active && rf_field_present) [*3] |=> !standby_active)
    else $error("sleeping listener ignored the field");
  chk_standby_wake: assert property (
    (standby_active && !listen_active && wake_event) [*3] |=> !standby_active)
    else $error("standby ignored the wake pin");
  chk_boot_event: assert property (boot_cnt_reg == 2'h2 |-> irq)
    else $error("no boot event after reset");

  cover property (listen_active && standby_active);
  cover property ($fell(listen_active));
  cover property (abort_keep);
  cover property (frontend_reset);
endmodule

bind opsw_ctrl opsw_ctrl_checker u_chk (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .rf_field_present, .target_activated, .wake_event,
  .soft_reset_req, .frontend_reset, .rf_field_off, .transceiver_idle, .standby_active,
  .listen_active, .listen_tech_enable, .irq);
`default_nettype wire

// file: opsw_host_model.sv
// Host controller model issuing command and status transfers over APB.
`timescale 1ns/100ps
`default_nettype none
module opsw_host_model (
  input wire logic mclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // Bus idles deselected from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer; address and data are inverted once released so stale values never linger.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: opsw_ctrl_tb_top.sv
// Self-checking testbench of the mode switch command interpreter.
`timescale 1ns/100ps
`default_nettype none
module opsw_ctrl_tb_top
  import opsw_pkg::*;
;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} opsw_note_t;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic rf_field_present = 1'b0;
  logic target_activated = 1'b0;
  logic wake_event = 1'b0;
  logic soft_reset_req = 1'b0;
  logic frontend_reset, rf_field_off, transceiver_idle, standby_active, listen_active, irq;
  logic [1:0] listen_tech_enable;
  logic [7:0] m;
  logic [7:0] busy_c [4] = '{OPSW_INSTR_EXCHANGE, OPSW_INSTR_TEST_SEQ, OPSW_INSTR_STANDBY,
    OPSW_INSTR_CARD_DETECT};
  logic [31:0] busy_s [4] = '{32'h3, 32'h3, 32'h1, 32'h2};
  logic [15:0] bad [3] = '{16'h0301, 16'h0204, 16'h0210};
  opsw_note_t notes [$];
  opsw_note_t n;
  int n_errors = 0;
  int total_checks = 0;

  always #12.5 mclk = ~mclk;

  opsw_ctrl u_dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rf_field_present, .target_activated, .wake_event, .soft_reset_req,
    .frontend_reset, .rf_field_off, .transceiver_idle, .standby_active, .listen_active,
    .listen_tech_enable, .irq);
  opsw_host_model u_host (.mclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);

  // ************************************************************
  // Helpers.
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] k);
    notes.push_back('{d, k, a > OPSW_MODE_OFFS});
    u_host.xfer(1'b0, a, 32'h00000000);
  endtask

  task automatic cmd(input logic [31:0] d);
    u_host.xfer(1'b1, OPSW_CMD_OFFS, d);
  endtask

  task automatic clr();
    u_host.xfer(1'b1, OPSW_EVT_OFFS, 32'h00000007);
  endtask

  // Pins pass two flops, so their effect is visible after three edges.
  task automatic field(input logic v);
    @(posedge mclk);
    rf_field_present <= v;
    repeat (4) @(posedge mclk);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares each completed read with the oldest expectation noted by the driver.
  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      total_checks++;
      if (notes.size() == 0) begin
        n_errors++;
        $display("BAD %0t read with no expectation", $time);
      end else begin
        n = notes.pop_front();
        if ((prdata & n.mask) !== n.data || pslverr !== n.err) begin
          n_errors++;
          $display("BAD %0t read %h gave %h", $time, paddr, prdata);
        end
      end
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    seed = 32'hdd35a67e;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rd(OPSW_EVT_OFFS, 32'h1, 32'h7);
    rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
    rd(8'h10, 32'h0, 32'hffffffff);
    clr();
    rd(OPSW_EVT_OFFS, 32'h0, 32'h7);
    cmd(32'h00000120);
    rd(OPSW_EVT_OFFS, 32'h1, 32'h7);
    rd(OPSW_RESP_OFFS, 32'h0, 32'h100);
    clr();
    for (int i = 0; i < 8; i++) begin
      cmd({24'h0, busy_c[i/2]});
      rd(OPSW_MODE_OFFS, busy_s[i/2], 32'h7);
      cmd({16'h0, i % 2 ? OPSW_SEL_ABORT_KEEP : OPSW_SEL_ABORT_RST, 8'h20});
      rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
      rd(OPSW_EVT_OFFS, 32'h2, 32'h7);
      clr();
    end
    for (int k = 0; k < 2; k++) begin
      // Standby (k=0) is left through the wake pin, card detect (k=1) through the soft reset pin.
      cmd({24'h0, k ? OPSW_INSTR_CARD_DETECT : OPSW_INSTR_STANDBY});
      cmd({24'h0, OPSW_INSTR_EXCHANGE});
      rd(OPSW_RESP_OFFS, 32'h101, 32'h1ff);
      rd(OPSW_MODE_OFFS, k ? 32'h2 : 32'h1, 32'h7);
      @(posedge mclk);
      soft_reset_req <= k[0];
      wake_event <= !k[0];
      repeat (4) @(posedge mclk);
      rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
      rd(OPSW_EVT_OFFS, 32'h2, 32'h7);
      soft_reset_req <= 1'b0;
      wake_event <= 1'b0;
      clr();
    end
    for (int b = 0; b < 3; b++) begin
      cmd({bad[b][15:8], 8'h00, bad[b][7:0], OPSW_INSTR_LISTEN});
      rd(OPSW_RESP_OFFS, 32'h101, 32'h1ff);
      rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
    end
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      m = (seed[1:0] == 2'b00) ? 8'h01 : {6'h0, seed[1:0]};
      field(1'b1);
      // Each listen command reloads mode and mask after the last normal entry.
      cmd({8'h02, 8'h00, m, OPSW_INSTR_LISTEN});
      rd(OPSW_RESP_OFFS, 32'h100, 32'h1ff);
      rd(OPSW_MODE_OFFS, {16'h02, m, 8'h04}, 32'h00ffff07);
      total_checks++;
      if (listen_tech_enable !== m[1:0]) begin
        n_errors++;
        $display("BAD %0t technology enables %b", $time, listen_tech_enable);
      end
      field(1'b0);
      rd(OPSW_MODE_OFFS, 32'h6, 32'h7);
      field(1'b1);
      rd(OPSW_MODE_OFFS, 32'h4, 32'h7);
      @(posedge mclk);
      target_activated <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
      rd(OPSW_EVT_OFFS, 32'h4, 32'h7);
      target_activated <= 1'b0;
      field(1'b0);
      clr();
    end
    cmd({8'h01, 8'h00, 8'h03, OPSW_INSTR_LISTEN});
    rd(OPSW_MODE_OFFS, 32'h5, 32'h7);
    field(1'b1);
    rd(OPSW_MODE_OFFS, 32'h4, 32'h7);
    field(1'b0);
    rd(OPSW_MODE_OFFS, 32'h5, 32'h7);
    cmd({16'h0, OPSW_SEL_ABORT_KEEP, 8'h20});
    rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
    clr();
    field(1'b1);
    cmd({8'h00, 8'h00, 8'h01, OPSW_INSTR_LISTEN});
    rd(OPSW_MODE_OFFS, 32'h4, 32'h7);
    field(1'b0);
    rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
    rd(OPSW_EVT_OFFS, 32'h4, 32'h7);
    clr();
    // A plain listen started without a field ends at once; a read consumes the status.
    cmd({8'h00, 8'h00, 8'h02, OPSW_INSTR_LISTEN});
    rd(OPSW_RESP_OFFS, 32'h100, 32'h1ff);
    rd(OPSW_RESP_OFFS, 32'h000, 32'h100);
    rd(OPSW_MODE_OFFS, 32'h0, 32'h7);
    rd(OPSW_EVT_OFFS, 32'h4, 32'h7);
    repeat (2) @(posedge mclk);
    summarize();
  end
endmodule
`default_nettype wire
